// ---- include/dtc_pkg.sv ----
// Shared constants of the dual timer/counter block
`default_nettype none
package dtc_pkg;
  // ==========================================================
  // Register addresses on the internal CPU bus
  localparam logic [15:0] ADR_IFR  = 16'h0011; // Flag bits
  localparam logic [15:0] ADR_IER  = 16'h0012; // Enable bits
  localparam logic [15:0] ADR_MCR  = 16'h0014; // Mode control
  localparam logic [15:0] ADR_A_LO = 16'h0018; // Count/latch A lo
  localparam logic [15:0] ADR_A_HI = 16'h0019; // Count/latch A hi
  localparam logic [15:0] ADR_A_LD = 16'h001A; // Load and start A
  localparam logic [15:0] ADR_B_LO = 16'h001C; // Count/latch B lo
  localparam logic [15:0] ADR_B_HI = 16'h001D; // Count/latch B hi
  localparam logic [15:0] ADR_B_LD = 16'h001E; // Load and start B
  // ==========================================================
  // Field positions
  localparam int FLAG_A_BIT = 4; // Timer one flag/enable bit
  localparam int FLAG_B_BIT = 5; // Timer two flag/enable bit
  localparam int MODE_A_LSB = 0; // Timer one mode field
  localparam int MODE_B_LSB = 2; // Timer two mode field
  // ==========================================================
  // Mode codes
  localparam logic [1:0] A_IVT  = 2'h0; // Interval timer
  localparam logic [1:0] A_PGEN = 2'h1; // Pulse generation
  localparam logic [1:0] A_EVT  = 2'h2; // Event counter
  localparam logic [1:0] A_PWM  = 2'h3; // Pulse width measure
  localparam logic [1:0] B_IVT  = 2'h0; // Interval timer
  localparam logic [1:0] B_APG  = 2'h1; // Asymmetrical pulses
  localparam logic [1:0] B_EVT  = 2'h2; // Event counter
  localparam logic [1:0] B_RTRG = 2'h3; // Retriggerable timer
  // ==========================================================
  // Reset values
  localparam logic [15:0] CNT_RST  = 16'hFFFF; // Counters
  localparam logic [15:0] LAT_RST  = 16'hFFFF; // Latches
  localparam logic [2:0]  SYNC_RST = 3'h7;     // Pins idle high
  localparam logic        PIN_RST  = 1'h1;     // Outputs high
endpackage : dtc_pkg
`default_nettype wire

// ---- verilog/dtc_pin_sync.sv ----
// Pin synchroniser with rising edge detect
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  // ==========================================================
  // State
  typedef struct packed {
    logic s1;   // First stage, read only by s2
    logic s2;   // Settled level
    logic prev; // Level one cycle earlier
  } dtc_sync_t;

  dtc_sync_t q;
  dtc_sync_t d;

  // Shift the pin through two stages and keep one history bit
  always_comb begin
    d      = q;
    d.s1   = pin_in;
    d.s2   = q.s1;
    d.prev = q.s2;
  end

  // Reset to idle high so a high pin gives no false edge
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= dtc_pkg::SYNC_RST;
    end else begin
      q <= d;
    end
  end

  assign level = q.s2;
  // Edges closer than two clocks merge, so half rate is the limit
  assign rise  = q.s2 & ~q.prev;
endmodule : dtc_pin_sync
`default_nettype wire

// ---- verilog/dtc_down_ctr.sv ----
// Down-counter with load, reload on underflow
`timescale 1ns/10ps
`default_nettype none
module dtc_down_ctr #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             dec,
  input  wire logic [WIDTH-1:0] reload_val,
  output logic      [WIDTH-1:0] count,
  output logic                  uflow
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] cnt; // Live count
  } dtc_ctr_t;

  dtc_ctr_t q;
  dtc_ctr_t d;

  // A load in the same cycle hides the underflow
  assign uflow = dec & ~load & (q.cnt == '0);

  // Load wins, then reload from zero, else decrement
  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_val;
    end else if (uflow) begin
      d.cnt = reload_val;
    end else if (dec) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // Register the count
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q <= WIDTH'(dtc_pkg::CNT_RST);
    end else begin
      q <= d;
    end
  end

  assign count = q.cnt;
endmodule : dtc_down_ctr
`default_nettype wire

// ---- verilog/dtc_timers.sv ----
// Dual 16-bit timer/counter with latches and pin modes
//
// Summary of operation
// - Pulse mode pin toggles on underflow, load
// - Entering pulse mode drives pin high
// - Event mode counts rising pin edges
// - Event mode underflow sets flag
// - Width mode counts only while pin low
// - Width mode reloads at zero, flags
// - Width mode holds count while pin high
// - Pin A level readable as port bit
// - Serial enable forces clock-rate counting
// - Shift-register receiver needs no timer one
// - Reads return live timer two bytes
// - Low/high writes fill latch B
// - Load write fills high, loads counter
// - Timer two reloads at zero, flags
// - Flag two clears on read/load/reset
// - Timer two interval and event like one
// - Retrigger reloads on edge; flag if first
// - Pulse mode high write copies latch C
// - Pulse mode load drives pin low
// - Underflows alternate latch C high, B low
// - Latch C used only in pulse mode
// - Two bits pick timer one mode
// - Load write fills high, loads counter
// - Timer one reloads, flags, clears
// - Interrupt when flag one and enable
`timescale 1ns/10ps
`default_nettype none
module dtc_timers (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // CPU bus
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  // Serial port controls
  input  wire logic        serial_enable,
  input  wire logic        receiver_shift_register_mode,
  output logic             baud_tick,
  // Pins
  input  wire logic        timer_one_pin_in,
  output logic             timer_one_pin_out,
  output logic             timer_one_pin_oe,
  input  wire logic        timer_two_pin_in,
  output logic             timer_two_pin_out,
  output logic             timer_two_pin_oe,
  output logic             port_a_bit_four,
  output logic             port_a_bit_five,
  // Flags and interrupts
  output logic             timer_one_underflow_flag,
  output logic             timer_two_underflow_flag,
  output logic             irq_timer_one,
  output logic             irq_timer_two
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] lat_a;   // Reload latch A
    logic [15:0] lat_b;   // Reload latch B
    logic [15:0] lat_c;   // Pulse width latch
    logic [1:0]  mode_a;  // Timer one mode
    logic [1:0]  mode_b;  // Timer two mode
    logic [1:0]  ien;     // Enables, A in bit 0
    logic        flag_a;  // Timer one underflow
    logic        flag_b;  // Timer two underflow
    logic        pin_a;   // Timer one output level
    logic        pin_b;   // Timer two output level
    logic        phase_b; // High phase of the pulse
    logic [7:0]  rdata;   // Registered read data
  } dtc_regs_t;

  dtc_regs_t q;
  dtc_regs_t d;

  // Address match of a write
  function automatic logic wr_at(input logic [15:0] a);
    return bus_wr && (bus_addr == a);
  endfunction : wr_at

  // ==========================================================
  // Pins and counters
  logic        lvl_a;  // Synchronised pin levels
  logic        lvl_b;
  logic        rise_a; // Rising edges
  logic        rise_b;
  logic [15:0] cnt_a;  // Live counts
  logic [15:0] cnt_b;
  logic        uf_a;   // Underflow pulses
  logic        uf_b;
  logic        dec_a;  // Count enables
  logic        dec_b;
  logic        ld_b;   // Counter B load request
  logic [15:0] ldv_b;  // Counter B load value
  logic [15:0] rlv_b;  // Counter B reload value
  logic        force_a; // Serial port owns timer one
  logic        wr_a_ld; // Decoded strobes
  logic        wr_b_ld;
  logic        wr_b_hi;
  logic        rd_a_lo;
  logic        rd_b_lo;

  assign wr_a_ld = wr_at(dtc_pkg::ADR_A_LD);
  assign wr_b_ld = wr_at(dtc_pkg::ADR_B_LD);
  assign wr_b_hi = wr_at(dtc_pkg::ADR_B_HI);
  assign rd_a_lo = bus_rd && (bus_addr == dtc_pkg::ADR_A_LO);
  assign rd_b_lo = bus_rd && (bus_addr == dtc_pkg::ADR_B_LO);

  // Pins are asynchronous, so both pass two flip-flops
  dtc_pin_sync u_sync_a (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin_in  (timer_one_pin_in),
    .level   (lvl_a),
    .rise    (rise_a)
  );

  dtc_pin_sync u_sync_b (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .pin_in  (timer_two_pin_in),
    .level   (lvl_b),
    .rise    (rise_b)
  );

  // Shift-register receiver clocks itself, so no forcing there
  assign force_a = serial_enable & ~receiver_shift_register_mode;

  // Timer one count enable by mode
  always_comb begin
    if (force_a) begin
      dec_a = 1'b1;
    end else begin
      case (q.mode_a)
        dtc_pkg::A_EVT: dec_a = rise_a;
        dtc_pkg::A_PWM: dec_a = ~lvl_a;
        default:        dec_a = 1'b1;    // Interval and pulse
      endcase
    end
  end

  // Load from high byte plus low latch
  dtc_down_ctr #(
    .WIDTH (16)
  ) u_ctr_a (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .load       (wr_a_ld),
    .load_val   ({bus_wdata, q.lat_a[7:0]}),
    .dec        (dec_a),
    .reload_val (q.lat_a),
    .count      (cnt_a),
    .uflow      (uf_a)
  );

  // Timer two enables, loads and reload source
  always_comb begin
    dec_b = (q.mode_b == dtc_pkg::B_EVT) ? rise_b : 1'b1;
    ld_b  = wr_b_ld;
    ldv_b = {bus_wdata, q.lat_b[7:0]};
    if (!wr_b_ld && q.mode_b == dtc_pkg::B_RTRG && rise_b) begin
      ld_b  = 1'b1;
      ldv_b = q.lat_b;
    end
    // Latch C matters only while generating pulses
    if (q.mode_b == dtc_pkg::B_APG && !q.phase_b) begin
      rlv_b = q.lat_c;
    end else begin
      rlv_b = q.lat_b;
    end
  end

  // A retrigger edge hides a same-cycle underflow, so no flag then
  dtc_down_ctr #(
    .WIDTH (16)
  ) u_ctr_b (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .load       (ld_b),
    .load_val   (ldv_b),
    .dec        (dec_b),
    .reload_val (rlv_b),
    .count      (cnt_b),
    .uflow      (uf_b)
  );

  // ==========================================================
  // Register writes, flags and pin outputs
  always_comb begin
    d = q;
    // Latch bytes
    if (wr_at(dtc_pkg::ADR_A_LO)) begin
      d.lat_a[7:0] = bus_wdata;
    end
    if (wr_at(dtc_pkg::ADR_A_HI) || wr_a_ld) begin
      d.lat_a[15:8] = bus_wdata;
    end
    if (wr_at(dtc_pkg::ADR_B_LO)) begin
      d.lat_b[7:0] = bus_wdata;
    end
    if (wr_b_hi || wr_b_ld) begin
      d.lat_b[15:8] = bus_wdata;
    end
    if (wr_b_hi && q.mode_b == dtc_pkg::B_APG) begin
      d.lat_c = {bus_wdata, q.lat_b[7:0]};
    end
    // Enables and modes
    if (wr_at(dtc_pkg::ADR_IER)) begin
      d.ien = {bus_wdata[dtc_pkg::FLAG_B_BIT],
               bus_wdata[dtc_pkg::FLAG_A_BIT]};
    end
    if (wr_at(dtc_pkg::ADR_MCR)) begin
      d.mode_a = bus_wdata[dtc_pkg::MODE_A_LSB +: 2];
      d.mode_b = bus_wdata[dtc_pkg::MODE_B_LSB +: 2];
    end
    // Entry to pulse mode starts from high
    if (d.mode_a == dtc_pkg::A_PGEN &&
        q.mode_a != dtc_pkg::A_PGEN) begin
      d.pin_a = 1'b1;
    end
    // First load after entry therefore drives low
    if (q.mode_a == dtc_pkg::A_PGEN && (uf_a || wr_a_ld)) begin
      d.pin_a = ~q.pin_a;
    end
    // Asymmetrical pulse sequencing
    if (q.mode_b == dtc_pkg::B_APG) begin
      if (wr_b_ld) begin
        d.pin_b   = 1'b0;
        d.phase_b = 1'b0;
      end else if (uf_b) begin
        d.pin_b   = ~q.phase_b;
        d.phase_b = ~q.phase_b;
      end
    end
    // Set wins over clear so no underflow is lost
    d.flag_a = (q.flag_a & ~(rd_a_lo | wr_a_ld)) | uf_a;
    d.flag_b = (q.flag_b & ~(rd_b_lo | wr_b_ld)) | uf_b;
    // Read data is captured on the read strobe
    if (bus_rd) begin
      case (bus_addr)
        dtc_pkg::ADR_A_LO: d.rdata = cnt_a[7:0];
        dtc_pkg::ADR_A_HI: d.rdata = cnt_a[15:8];
        dtc_pkg::ADR_B_LO: d.rdata = cnt_b[7:0];
        dtc_pkg::ADR_B_HI: d.rdata = cnt_b[15:8];
        dtc_pkg::ADR_MCR:  d.rdata = {4'h0, q.mode_b, q.mode_a};
        dtc_pkg::ADR_IER:  d.rdata = {2'h0, q.ien, 4'h0};
        dtc_pkg::ADR_IFR:  d.rdata = {2'h0, q.flag_b, q.flag_a, 4'h0};
        default:           d.rdata = 8'h00; // Unmapped
      endcase
    end
  end

  // Register all control state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      q         <= '0;
      q.lat_a   <= dtc_pkg::LAT_RST;
      q.lat_b   <= dtc_pkg::LAT_RST;
      q.lat_c   <= dtc_pkg::LAT_RST;
      q.mode_a  <= dtc_pkg::A_IVT;
      q.mode_b  <= dtc_pkg::B_IVT;
      q.pin_a   <= dtc_pkg::PIN_RST;
      q.pin_b   <= dtc_pkg::PIN_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign bus_rdata         = q.rdata;
  assign baud_tick         = uf_a; // Sixteen ticks per bit
  assign timer_one_pin_out = q.pin_a;
  assign timer_one_pin_oe  = (q.mode_a == dtc_pkg::A_PGEN);
  assign timer_two_pin_out = q.pin_b;
  assign timer_two_pin_oe  = (q.mode_b == dtc_pkg::B_APG);
  assign port_a_bit_four   = lvl_a;
  assign port_a_bit_five   = lvl_b;
  assign timer_one_underflow_flag = q.flag_a;
  assign timer_two_underflow_flag = q.flag_b;
  assign irq_timer_one = q.flag_a & q.ien[0];
  assign irq_timer_two = q.flag_b & q.ien[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_a_reload;
    (cnt_a == 16'h0000) && dec_a && !wr_a_ld
      |=> cnt_a == $past(q.lat_a) && q.flag_a;
  endproperty
  a_a_reload: assert property (p_a_reload)
    else $error("timer one did not reload and flag");

  property p_a_clear;
    rd_a_lo && !uf_a |=> !q.flag_a;
  endproperty
  a_a_clear: assert property (p_a_clear)
    else $error("timer one flag not cleared by read");

  property p_pgen_tog;
    q.mode_a == dtc_pkg::A_PGEN && wr_a_ld
      |=> q.pin_a != $past(q.pin_a) ##1 !$stable(cnt_a);
  endproperty
  a_pgen_tog: assert property (p_pgen_tog)
    else $error("pulse output did not toggle on load");

  property p_pwm_hold;
    q.mode_a == dtc_pkg::A_PWM && lvl_a && !force_a && !wr_a_ld
      |=> $stable(cnt_a);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold)
    else $error("width count moved while pin high");

  property p_rtrg;
    q.mode_b == dtc_pkg::B_RTRG && rise_b && !wr_b_ld
      |=> cnt_b == $past(q.lat_b) && !$rose(q.flag_b);
  endproperty
  a_rtrg: assert property (p_rtrg)
    else $error("retrigger edge did not reload quietly");

  property p_b_load;
    wr_b_ld |=> cnt_b == {$past(bus_wdata), $past(q.lat_b[7:0])}
      && !q.flag_b;
  endproperty
  a_b_load: assert property (p_b_load)
    else $error("timer two load value wrong");

  sequence s_apg_low_uf;
    q.mode_b == dtc_pkg::B_APG && uf_b && !q.phase_b;
  endsequence
  property p_apg;
    s_apg_low_uf |=> q.pin_b && cnt_b == $past(q.lat_c);
  endproperty
  a_apg: assert property (p_apg)
    else $error("pulse phase did not load width latch");

  property p_irq;
    uf_a && q.ien[0] && !wr_at(dtc_pkg::ADR_IER) |=> irq_timer_one;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt after enabled underflow");

  property p_rd_hi;
    bus_rd && bus_addr == dtc_pkg::ADR_B_HI
      |=> bus_rdata == $past(cnt_b[15:8]);
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("timer two high byte read wrong");
endmodule : dtc_timers
`default_nettype wire

// ---- sim/dtc_pin_model.sv ----
// Outside sources wired to the two timer pins
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
  input  wire logic clk_sys,
  input  wire logic one_out,
  input  wire logic one_oe,
  input  wire logic two_out,
  input  wire logic two_oe,
  output logic      one_in,
  output logic      two_in
);
  // ==========================================================
  // Pin drive
  // Levels put on the pins from outside, idle high like a pull-up
  logic [1:0] drv = 2'h3;
  // The device wins while it drives; otherwise the outside level shows
  assign one_in = one_oe ? one_out : drv[0];
  assign two_in = two_oe ? two_out : drv[1];
  // ==========================================================
  // Event pulses, two cycles high and two low, never above half rate
  task automatic pulses(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      drv[sel] = 1'b1;
      repeat (2) @(negedge clk_sys);
      drv[sel] = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
  endtask : pulses
endmodule : dtc_pin_model
`default_nettype wire

// ---- sim/tb_dtc_timers.sv ----
// Self-checking bench for the dual timer/counter block
`timescale 1ns/10ps
`default_nettype none
module tb_dtc_timers;
  logic        clk_sys = 1'b0; // 100 MHz clock
  logic        rst_b;         // Synchronous reset, active low
  logic [15:0] bus_addr;      // CPU address
  logic [7:0]  bus_wdata;     // Write data
  logic        bus_wr;        // Write strobe
  logic        bus_rd;        // Read strobe
  logic [7:0]  bus_rdata;     // Registered read data
  logic        serial_enable; // Serial port on
  logic        rx_sr_mode;    // Receiver in shift-register mode
  logic        one_in;        // Resolved pin levels and drives
  logic        one_out;
  logic        one_oe;
  logic        two_in;
  logic        two_out;
  logic        two_oe;
  logic        port_four;     // Synchronised pin levels
  logic        port_five;
  logic        flag_one;      // Underflow flags
  logic        flag_two;
  logic        irq_one;       // Interrupt requests
  logic        irq_two;
  logic        baud;          // Bit-rate tick
  logic [7:0]  rdv;           // Last value read back
  int          fails;         // Mismatches seen
  int          checks;        // Comparisons made

  dtc_timers dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .serial_enable(serial_enable),
    .receiver_shift_register_mode(rx_sr_mode), .baud_tick(baud),
    .timer_one_pin_in(one_in), .timer_one_pin_out(one_out),
    .timer_one_pin_oe(one_oe), .timer_two_pin_in(two_in),
    .timer_two_pin_out(two_out), .timer_two_pin_oe(two_oe),
    .port_a_bit_four(port_four), .port_a_bit_five(port_five),
    .timer_one_underflow_flag(flag_one),
    .timer_two_underflow_flag(flag_two),
    .irq_timer_one(irq_one), .irq_timer_two(irq_two));

  dtc_pin_model pins (
    .clk_sys(clk_sys), .one_out(one_out), .one_oe(one_oe),
    .two_out(two_out), .two_oe(two_oe), .one_in(one_in),
    .two_in(two_in));

  // ==========================================================
  // Clock, bus tasks and verdict
  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Strobes stay up after each access so back-to-back calls never
  // assign them twice in one step; idle drops them
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_rd = 1'b0;
    bus_wr = 1'b1;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [15:0] a);
    bus_addr = a;
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    @(negedge clk_sys);
    rdv = bus_rdata;
  endtask : rd

  task automatic idle(input int n);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask : idle

  task automatic give_verdict();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    repeat (3000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    rst_b = 1'b0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    serial_enable = 1'b0;
    rx_sr_mode = 1'b0;
    fails = 0;
    checks = 0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    check("pin one out", 8'(one_out), 8'h01);
    check("flag two", 8'(flag_two), 8'h00);
    rd(16'h0020);
    check("unmapped read", rdv, 8'h00);
    check("port bit five high", 8'(port_five), 8'h01);
    wr(dtc_pkg::ADR_IER, 8'h30);
    // Live bytes of timer two after a load
    wr(dtc_pkg::ADR_B_LO, 8'h34);
    wr(dtc_pkg::ADR_B_LD, 8'h12);
    rd(dtc_pkg::ADR_B_LO);
    check("count two low", rdv, 8'h34);
    rd(dtc_pkg::ADR_B_HI);
    check("count two high", rdv, 8'h12);
    // Underflow reloads the latch, sets and clears the flag
    wr(dtc_pkg::ADR_B_LO, 8'h10);
    wr(dtc_pkg::ADR_B_LD, 8'h00);
    check("flag two after load", 8'(flag_two), 8'h00);
    idle(16);
    check("flag two early", 8'(flag_two), 8'h00);
    idle(1);
    check("flag two set", 8'(flag_two), 8'h01);
    check("irq two", 8'(irq_two), 8'h01);
    rd(dtc_pkg::ADR_B_LO);
    check("reload two", rdv, 8'h10);
    idle(1);
    check("flag two cleared", 8'(flag_two), 8'h00);
    // Pulse generation on pin one
    wr(dtc_pkg::ADR_A_LO, 8'h03);
    wr(dtc_pkg::ADR_MCR, {6'h00, dtc_pkg::A_PGEN});
    check("pin one entry", 8'({one_oe, one_out}), 8'h03);
    wr(dtc_pkg::ADR_A_LD, 8'h00);
    check("pin one load", 8'(one_out), 8'h00);
    idle(2);
    check("pin one half", 8'(one_out), 8'h00);
    idle(4);
    check("pin one rise", 8'(one_out), 8'h01);
    idle(4);
    check("pin one fall", 8'(one_out), 8'h00);
    // Event counting on pin one, then forced by the serial port
    pins.drv[0] = 1'b0;
    wr(dtc_pkg::ADR_MCR, {6'h00, dtc_pkg::A_EVT});
    wr(dtc_pkg::ADR_A_LO, 8'h10);
    wr(dtc_pkg::ADR_A_LD, 8'h00);
    idle(1);
    pins.pulses(0, 3);
    idle(4);
    rd(dtc_pkg::ADR_A_LO);
    check("events one", rdv, 8'h0D);
    serial_enable = 1'b1;
    idle(2);
    rd(dtc_pkg::ADR_A_LO);
    check("forced count", rdv, 8'h0B);
    rx_sr_mode = 1'b1;
    idle(3);
    rd(dtc_pkg::ADR_A_LO);
    check("no force shift mode", rdv, 8'h0A);
    // Forced again: count 0A runs out, then every latch plus one cycles
    rx_sr_mode = 1'b0;
    idle(10);
    check("baud first tick", 8'(baud), 8'h01);
    idle(16);
    check("baud between ticks", 8'(baud), 8'h00);
    idle(1);
    check("baud second tick", 8'(baud), 8'h01);
    serial_enable = 1'b0;
    // Pulse width measurement
    pins.drv[0] = 1'b1;
    wr(dtc_pkg::ADR_MCR, {6'h00, dtc_pkg::A_PWM});
    wr(dtc_pkg::ADR_A_LO, 8'h50);
    wr(dtc_pkg::ADR_A_LD, 8'h00);
    idle(5);
    rd(dtc_pkg::ADR_A_LO);
    check("width held", rdv, 8'h50);
    check("port bit high", 8'(port_four), 8'h01);
    pins.drv[0] = 1'b0;
    idle(10);
    check("port bit low", 8'(port_four), 8'h00);
    pins.drv[0] = 1'b1;
    idle(5);
    rd(dtc_pkg::ADR_A_LO);
    check("width count", rdv, 8'h46);
    wr(dtc_pkg::ADR_A_LO, 8'h03);
    wr(dtc_pkg::ADR_A_LD, 8'h00);
    check("flag one after load", 8'(flag_one), 8'h00);
    pins.drv[0] = 1'b0;
    idle(7);
    pins.drv[0] = 1'b1;
    idle(4);
    check("flag one set", 8'(flag_one), 8'h01);
    check("irq one", 8'(irq_one), 8'h01);
    rd(dtc_pkg::ADR_A_LO);
    check("width reload", rdv, 8'h00);
    idle(1);
    check("flag one cleared", 8'(flag_one), 8'h00);
    // Asymmetrical pulses: width 3 cycles from latch C (2), gap 5 from latch B (4)
    wr(dtc_pkg::ADR_MCR, {4'h0, dtc_pkg::B_APG, 2'h0});
    wr(dtc_pkg::ADR_B_LO, 8'h02);
    wr(dtc_pkg::ADR_B_HI, 8'h00);
    wr(dtc_pkg::ADR_B_LO, 8'h04);
    wr(dtc_pkg::ADR_B_LD, 8'h00);
    check("pin two start", 8'({two_oe, two_out}), 8'h02);
    idle(3);
    check("pin two gap", 8'(two_out), 8'h00);
    idle(4);
    check("pin two pulse", 8'(two_out), 8'h01);
    idle(3);
    check("pin two width", 8'(two_out), 8'h00);
    idle(4);
    check("pin two again", 8'(two_out), 8'h01);
    // Retriggered timer keeps its flag clear while edges come
    pins.drv[1] = 1'b0;
    wr(dtc_pkg::ADR_MCR, {4'h0, dtc_pkg::B_RTRG, 2'h0});
    wr(dtc_pkg::ADR_B_LO, 8'h08);
    wr(dtc_pkg::ADR_B_LD, 8'h00);
    idle(1);
    pins.pulses(1, 6);
    check("retrigger no flag", 8'(flag_two), 8'h00);
    idle(12);
    check("retrigger flag", 8'(flag_two), 8'h01);
    // Underflow reloaded latch B (8), not latch C (2)
    rd(dtc_pkg::ADR_B_LO);
    check("reload ignores c", rdv, 8'h04);
    // Event counting on pin two
    wr(dtc_pkg::ADR_MCR, {4'h0, dtc_pkg::B_EVT, 2'h0});
    wr(dtc_pkg::ADR_B_LO, 8'h09);
    wr(dtc_pkg::ADR_B_LD, 8'h00);
    idle(1);
    pins.pulses(1, 4);
    idle(4);
    rd(dtc_pkg::ADR_B_LO);
    check("events two", rdv, 8'h05);
    check("port bit five low", 8'(port_five), 8'h00);
    // Control registers read back; timer one keeps underflowing
    rd(dtc_pkg::ADR_MCR);
    check("mode read", rdv, 8'h08);
    rd(dtc_pkg::ADR_IER);
    check("enable read", rdv, 8'h30);
    rd(dtc_pkg::ADR_IFR);
    check("flag read", rdv, 8'h10);
    idle(1);
    give_verdict();
  end
endmodule : tb_dtc_timers
`default_nettype wire
